// ---- hw/psfc_pkg.sv ----
// Package for the power-stage fault and capture controller.
// Assumes a 32-bit classic Wishbone slave port and one 25 MHz clock.
package psfc_pkg;

  // ********************************
  // Register offsets (byte addresses)
  // ********************************
  localparam logic [7:0] ADDR_GEN_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_INPUT_A_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_INPUT_B_CONTROL = 8'h08;
  localparam logic [7:0] ADDR_CAPTURE_LOW = 8'h0c;
  localparam logic [7:0] ADDR_CAPTURE_HIGH = 8'h10;
  localparam logic [7:0] ADDR_OUTPUT_MATRIX = 8'h14;
  localparam logic [7:0] ADDR_GEN0_IRQ_MASK = 8'h18;
  localparam logic [7:0] ADDR_GEN1_IRQ_MASK = 8'h1c;
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  localparam logic [7:0] ADDR_OUTPUT_CONFIG = 8'h24;

  // ********************************
  // Field positions and reset values
  // ********************************
  localparam int BIT_RUN = 0;
  localparam int BIT_COMPLETE_CYCLE = 1;
  localparam int BIT_AUTORUN = 2;
  localparam int BIT_ASYNC_A = 3;
  localparam int BIT_CAPTURE_EN = 7;
  localparam int BIT_SOURCE_SEL = 6;
  localparam int BIT_EDGE_LEVEL = 5;
  localparam int BIT_FILTER_EN = 4;
  localparam int BIT_SW_TRIGGER = 7;
  localparam int BIT_MATRIX_EN = 0;
  localparam int BIT_POLARITY = 1;
  localparam int BIT_IRQ_EOC = 0;
  localparam int BIT_IRQ_EVA = 3;
  localparam int BIT_IRQ_EVB = 4;
  localparam int BIT_IRQ_SYNC = 5;
  localparam logic [7:0] IRQ_MASK_USED = 8'h39;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int MATRIX_B_BASE = 4;

  // ********************************
  // Mode codes and timing
  // ********************************
  localparam logic [3:0] MODE_IGNORE = 4'h0;
  localparam logic [3:0] MODE_FAULT_LAST = 4'h7;
  localparam logic [3:0] MODE_RETRIGGER = 4'h8;
  localparam logic [3:0] MODE_FIXED_RETRIG = 4'h9;
  localparam logic [3:0] MODE_FIXED_DEACT = 4'he;
  localparam int FILTER_SAMPLES = 4;
  localparam int CAPTURE_WIDTH = 12;
  localparam int NUM_BLOCKS = 2;

  // Fields of one input control register
  typedef struct packed {
    logic capture_enable;
    logic input_source_select;
    logic edge_level_select;
    logic noise_filter_enable;
    logic [3:0] fault_retrigger_mode;
  } psfc_input_ctrl_t;

  // Decoded action of one retrigger/fault block
  typedef struct packed {
    logic fault_active;
    logic [2:0] fault_mode;
    logic retrigger;
    logic fixed_frequency;
    logic deactivate;
    logic event_pulse;
  } psfc_block_action_t;

  // Run control state of the third generator
  typedef enum logic [2:0] {
    ST_STOPPED = 3'b001,
    ST_RUNNING = 3'b010,
    ST_FINISHING = 3'b100
  } psfc_run_state_t;

endpackage

// ---- hw/psfc_ctrl.sv ----
// Run control, retrigger/fault inputs, capture, output matrix and masks
// of the third power-stage generator. Assumes the waveform engine sits
// outside and supplies counter, ramp, wave levels and cycle-end pulses.
`timescale 1ns/1ps

// Overview of operation
// [RULE_01] Async control A forces A pins unclocked
// [RULE_02] Autorun follows gen1 run or chain
// [RULE_03] Complete cycle finishes before halt, not slave
// [RULE_04] Run bit starts, prevails over autorun
// [RULE_05] Two identical input blocks A and B
// [RULE_06] Capture enable captures on input event
// [RULE_07] Source select: pin or comparator
// [RULE_08] Edge/level bit picks event polarity
// [RULE_09] Filter needs four equal samples
// [RULE_10] Codes 0 ignore, 1-7 fault modes
// [RULE_11] Codes 8, 9, 14 retrigger variants
// [RULE_12] Software avoids reserved mode codes
// [RULE_13] Software trigger captures, read shows source
// [RULE_14] Capture loads counter on each event
// [RULE_15] Twelve-bit capture read via temp byte
// [RULE_16] Matrix high nibble drives output B
// [RULE_17] Matrix low nibble drives output A
// [RULE_18] Mask bits 5,4,3,0; others zero
// [RULE_19] End-of-cycle enable requests interrupt
// [RULE_20] Matrix enable overrides output polarity
// [RULE_21] All fields reset to zero; the status state field resets to ST_STOPPED (001)
// [RULE_22] Filter samples every input clock
module psfc_ctrl
  import psfc_pkg::*;
#(
  parameter int FILTER_DEPTH = FILTER_SAMPLES,
  parameter int CAP_W = CAPTURE_WIDTH
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Wishbone classic slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // Other generators and the waveform engine
  input wire logic run_gen0_in,
  input wire logic run_gen1_in,
  input wire logic autorun_gen1_in,
  input wire logic gen0_cycle_end_in,
  input wire logic gen1_cycle_end_in,
  input wire logic gen2_cycle_end_in,
  input wire logic [1:0] sync_error_in,
  input wire logic [CAP_W-1:0] counter_in,
  input wire logic [1:0] ramp_in,
  input wire logic wave_a_in,
  input wire logic wave_b_in,
  // Fault and comparator inputs
  input wire logic generator_input_pin_in,
  input wire logic comparator_in,
  // Results
  output logic run_gen2_out,
  output psfc_block_action_t action_a_out,
  output psfc_block_action_t action_b_out,
  output logic [1:0] irq_request_out,
  output logic gen2_out_a0_out,
  output logic gen2_out_b0_out,
  output logic gen2_out_a1_out,
  output logic gen2_out_b1_out
);

  // ********************************
  // Register storage
  // ********************************
  logic [7:0] gen_control_r;
  psfc_input_ctrl_t input_ctrl_r [NUM_BLOCKS];
  logic [7:0] output_matrix_r;
  logic [7:0] irq_mask_r [2];
  logic [1:0] output_config_r;
  logic [CAP_W-1:0] capture_r;
  logic sw_capture_r;
  logic [7:0] temp_high_r;
  logic [31:0] rd_data_r;
  logic ack_r;
  psfc_run_state_t state_r;
  psfc_run_state_t state_nxt;
  logic [FILTER_DEPTH-2:0] sample_r [NUM_BLOCKS];
  logic [NUM_BLOCKS-1:0] filtered_r;
  logic [NUM_BLOCKS-1:0] active_prev_r;
  psfc_block_action_t action_r [NUM_BLOCKS];
  logic [1:0] irq_r;
  logic out_a_r;
  logic out_b_r;

  // Mode decode, shared by both blocks
  function automatic psfc_block_action_t decode_mode(input logic [3:0] mode, input logic active,
                                                     input logic evt);
    psfc_block_action_t res;
    res = '0;
    // [RULE_10] fault modes one to seven
    if (mode != MODE_IGNORE && mode <= MODE_FAULT_LAST) begin
      res.fault_active = active;
      res.fault_mode = mode[2:0];
    end
    // [RULE_11] retrigger variants
    res.retrigger = evt && (mode == MODE_RETRIGGER);
    res.fixed_frequency = evt && (mode == MODE_FIXED_RETRIG || mode == MODE_FIXED_DEACT);
    res.deactivate = evt && (mode == MODE_FIXED_DEACT);
    res.event_pulse = evt && (mode != MODE_IGNORE);
    return res;
  endfunction

  // ********************************
  // Bus decode
  // ********************************
  wire bus_req = wb_cyc_in && wb_stb_in && !ack_r;
  wire bus_wr = bus_req && wb_we_in && wb_sel_in[0];
  wire bus_rd = bus_req && !wb_we_in;
  wire [7:0] wr_byte = wb_dat_in[7:0];
  wire wr_control = bus_wr && (wb_adr_in == ADDR_GEN_CONTROL);
  wire wr_input_a = bus_wr && (wb_adr_in == ADDR_INPUT_A_CONTROL);
  wire wr_input_b = bus_wr && (wb_adr_in == ADDR_INPUT_B_CONTROL);
  wire wr_cap_high = bus_wr && (wb_adr_in == ADDR_CAPTURE_HIGH);
  wire wr_matrix = bus_wr && (wb_adr_in == ADDR_OUTPUT_MATRIX);
  wire wr_mask0 = bus_wr && (wb_adr_in == ADDR_GEN0_IRQ_MASK);
  wire wr_mask1 = bus_wr && (wb_adr_in == ADDR_GEN1_IRQ_MASK);
  wire wr_outcfg = bus_wr && (wb_adr_in == ADDR_OUTPUT_CONFIG);
  // [RULE_15] low byte read latches the high byte
  wire rd_cap_low = bus_rd && (wb_adr_in == ADDR_CAPTURE_LOW);
  // [RULE_13] software trigger strobe
  wire sw_trigger = wr_cap_high && wr_byte[BIT_SW_TRIGGER];

  // Control fields
  wire run_bit = gen_control_r[BIT_RUN];
  wire complete_cycle_gen2 = gen_control_r[BIT_COMPLETE_CYCLE];
  wire autorun_gen2 = gen_control_r[BIT_AUTORUN];
  wire async_out_ctrl_a = gen_control_r[BIT_ASYNC_A];
  wire matrix_enable = output_config_r[BIT_MATRIX_EN];
  wire output_polarity = output_config_r[BIT_POLARITY];

  // Read mux; unmapped addresses read zero
  wire [CAP_W-1:0] cap_pad = capture_r;
  wire [7:0] cap_high_live = {sw_capture_r, 3'h0, cap_pad[CAP_W-1:8]};
  logic [7:0] rd_byte;
  always_comb begin
    case (wb_adr_in)
      ADDR_GEN_CONTROL: rd_byte = gen_control_r;
      ADDR_INPUT_A_CONTROL: rd_byte = input_ctrl_r[0];
      ADDR_INPUT_B_CONTROL: rd_byte = input_ctrl_r[1];
      ADDR_CAPTURE_LOW: rd_byte = capture_r[7:0];
      ADDR_CAPTURE_HIGH: rd_byte = temp_high_r;
      ADDR_OUTPUT_MATRIX: rd_byte = output_matrix_r;
      // [RULE_18] unused mask bits read zero
      ADDR_GEN0_IRQ_MASK: rd_byte = irq_mask_r[0] & IRQ_MASK_USED;
      ADDR_GEN1_IRQ_MASK: rd_byte = irq_mask_r[1] & IRQ_MASK_USED;
      ADDR_STATUS: rd_byte = {3'h0, filtered_r, state_r};
      ADDR_OUTPUT_CONFIG: rd_byte = {6'h00, output_config_r};
      default: rd_byte = RESET_BYTE;
    endcase
  end

  // ********************************
  // Register writes
  // ********************************
  // [RULE_21] every writable field clears on reset
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      gen_control_r <= RESET_BYTE;
      input_ctrl_r[0] <= '0;
      input_ctrl_r[1] <= '0;
      output_matrix_r <= RESET_BYTE;
      irq_mask_r[0] <= RESET_BYTE;
      irq_mask_r[1] <= RESET_BYTE;
      output_config_r <= 2'h0;
    end else begin
      if (wr_control) gen_control_r <= {4'h0, wr_byte[3:0]};
      // [RULE_05] identical layout per block
      if (wr_input_a) input_ctrl_r[0] <= wr_byte;
      if (wr_input_b) input_ctrl_r[1] <= wr_byte;
      if (wr_matrix) output_matrix_r <= wr_byte;
      // [RULE_18] only the four enables are stored
      if (wr_mask0) irq_mask_r[0] <= wr_byte & IRQ_MASK_USED;
      if (wr_mask1) irq_mask_r[1] <= wr_byte & IRQ_MASK_USED;
      if (wr_outcfg) output_config_r <= wr_byte[1:0];
    end
  end

  // Bus answer: one-cycle ack after the request edge
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ack_r <= 1'b0;
      rd_data_r <= 32'h0000_0000;
    end else begin
      ack_r <= bus_req;
      rd_data_r <= {24'h00_0000, rd_byte};
    end
  end

  assign wb_ack_out = ack_r;
  assign wb_dat_out = rd_data_r;

  // ********************************
  // Input blocks A and B
  // ********************************
  logic [NUM_BLOCKS-1:0] raw_in;
  logic [NUM_BLOCKS-1:0] raw_active;
  logic [NUM_BLOCKS-1:0] active_now;
  logic [NUM_BLOCKS-1:0] block_event;
  logic [NUM_BLOCKS-1:0] capture_event;
  psfc_block_action_t action_nxt [NUM_BLOCKS];

  for (genvar b = 0; b < NUM_BLOCKS; b++) begin : g_blk
    // [RULE_07] pin when clear, comparator when set
    assign raw_in[b] = input_ctrl_r[b].input_source_select ? comparator_in : generator_input_pin_in;
    // [RULE_08] set selects high/rising
    assign raw_active[b] = input_ctrl_r[b].edge_level_select ? raw_in[b] : !raw_in[b];
    wire filt_lvl = input_ctrl_r[b].noise_filter_enable ? filtered_r[b] : raw_in[b];
    assign active_now[b] = input_ctrl_r[b].edge_level_select ? filt_lvl : !filt_lvl;
    assign block_event[b] = active_now[b] && !active_prev_r[b];
    // [RULE_06] capture only when enabled
    assign capture_event[b] = block_event[b] && input_ctrl_r[b].capture_enable;
    assign action_nxt[b] = decode_mode(input_ctrl_r[b].fault_retrigger_mode, active_now[b],
                                       block_event[b]);

    // [RULE_22] sample every clock, before detection
    always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
        sample_r[b] <= '0;
        filtered_r[b] <= 1'b0;
      end else begin
        sample_r[b] <= (FILTER_DEPTH-1)'({sample_r[b], raw_in[b]});
        // [RULE_09] live sample plus held ones, no extra cycle
        if (&{sample_r[b], raw_in[b]}) filtered_r[b] <= 1'b1;
        else if (~|{sample_r[b], raw_in[b]}) filtered_r[b] <= 1'b0;
      end
    end

    // Edge history and registered action
    always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
        active_prev_r[b] <= 1'b0;
        action_r[b] <= '0;
      end else begin
        active_prev_r[b] <= active_now[b];
        action_r[b] <= action_nxt[b];
      end
    end
  end

  assign action_a_out = action_r[0];
  assign action_b_out = action_r[1];

  // ********************************
  // Capture register
  // ********************************
  // Software trigger wins a same-cycle clash with an input event
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      capture_r <= '0;
      sw_capture_r <= 1'b0;
      temp_high_r <= RESET_BYTE;
    end else begin
      // [RULE_13] software capture marks its source
      if (sw_trigger) begin
        capture_r <= counter_in;
        sw_capture_r <= 1'b1;
      // [RULE_14] input event loads the counter
      end else if (|capture_event) begin
        capture_r <= counter_in;
        sw_capture_r <= 1'b0;
      end
      // [RULE_15] high byte frozen for the next read
      if (rd_cap_low) temp_high_r <= cap_high_live;
    end
  end

  // ********************************
  // Run control of generator two
  // ********************************
  // [RULE_02] autorun start chain
  wire autorun_start = autorun_gen2 && (run_gen1_in || (autorun_gen1_in && run_gen0_in));
  // [RULE_04] run bit prevails over autorun
  wire run_request = run_bit || autorun_start;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_STOPPED: begin
        if (run_request) state_nxt = ST_RUNNING;
      end
      ST_RUNNING: begin
        // [RULE_03] finish cycle unless slaved
        if (!run_request) begin
          if (complete_cycle_gen2 && !autorun_gen2 && !gen2_cycle_end_in) state_nxt = ST_FINISHING;
          else state_nxt = ST_STOPPED;
        end
      end
      ST_FINISHING: begin
        if (run_request) state_nxt = ST_RUNNING;
        else if (gen2_cycle_end_in) state_nxt = ST_STOPPED;
      end
      default: state_nxt = ST_STOPPED;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) state_r <= ST_STOPPED;
    else state_r <= state_nxt;
  end

  // Run level registered from the next state
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) run_gen2_out <= 1'b0;
    else run_gen2_out <= (state_nxt != ST_STOPPED);
  end

  // ********************************
  // Interrupt requests
  // ********************************
  // Flags themselves live outside; this only gates events by the masks
  wire [1:0] cycle_end = {gen1_cycle_end_in, gen0_cycle_end_in};
  logic [1:0] irq_nxt;
  always_comb begin
    irq_nxt = 2'h0;
    for (int g = 0; g < 2; g++) begin
      // [RULE_19] end of whole cycle
      irq_nxt[g] = (irq_mask_r[g][BIT_IRQ_EOC] && cycle_end[g])
                || (irq_mask_r[g][BIT_IRQ_EVA] && action_nxt[0].event_pulse)
                || (irq_mask_r[g][BIT_IRQ_EVB] && action_nxt[1].event_pulse)
                || (irq_mask_r[g][BIT_IRQ_SYNC] && sync_error_in[g]);
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) irq_r <= 2'h0;
    else irq_r <= irq_nxt;
  end

  assign irq_request_out = irq_r;

  // ********************************
  // Output stage
  // ********************************
  // [RULE_17] low nibble indexed by ramp
  wire matrix_a = output_matrix_r[ramp_in];
  // [RULE_16] high nibble indexed by ramp
  wire matrix_b = output_matrix_r[MATRIX_B_BASE + 32'(ramp_in)];
  // Polarity clear means active low
  wire pol_a = output_polarity ? wave_a_in : !wave_a_in;
  wire pol_b = output_polarity ? wave_b_in : !wave_b_in;
  wire inactive_lvl = matrix_enable ? 1'b0 : !output_polarity;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      out_a_r <= 1'b0;
      out_b_r <= 1'b0;
    end else begin
      // [RULE_20] matrix bypasses polarity
      out_a_r <= matrix_enable ? matrix_a : pol_a;
      out_b_r <= matrix_enable ? matrix_b : pol_b;
    end
  end

  // Unclocked fault path: a stalled clock must not hold a pin on
  // [RULE_01] block A fault forces A pins directly
  wire async_kill_a = async_out_ctrl_a && (input_ctrl_r[0].fault_retrigger_mode != MODE_IGNORE)
                   && raw_active[0];
  assign gen2_out_a0_out = async_kill_a ? inactive_lvl : out_a_r;
  assign gen2_out_a1_out = async_kill_a ? inactive_lvl : out_a_r;
  assign gen2_out_b0_out = out_b_r;
  assign gen2_out_b1_out = out_b_r;

endmodule // psfc_ctrl

// ---- verification/psfc_chk.sv ----
// Port checker for the power-stage fault and capture controller.
// Assumes it is bound to psfc_ctrl; one clock, synchronous reset.
`timescale 1ns/1ps
module psfc_chk
  import psfc_pkg::*;
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  input wire logic run_gen2_out,
  input wire psfc_block_action_t action_a_out,
  input wire psfc_block_action_t action_b_out,
  input wire logic [1:0] irq_request_out,
  input wire logic gen2_out_a0_out,
  input wire logic gen2_out_b0_out,
  input wire logic gen2_out_a1_out,
  input wire logic gen2_out_b1_out
);
  // ********************************
  // Properties
  // ********************************
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  // Slave answers every request on the next edge
  AST_ACK_NEXT: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("ack missing after request");
  // Ack is a single pulse, so a held request is not taken twice
  AST_ACK_PULSE: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  AST_RST_CLEAR: assert property ($fell(sys_rst_in) |-> !run_gen2_out && irq_request_out == 2'b00
    && action_a_out == '0)
    else $error("outputs not clear after reset");
  AST_MASK_RSVD: assert property (wb_ack_out && !wb_we_in
    && (wb_adr_in == ADDR_GEN0_IRQ_MASK || wb_adr_in == ADDR_GEN1_IRQ_MASK)
    |-> wb_dat_out == {24'h0, wb_dat_out[7:0] & IRQ_MASK_USED})
    else $error("reserved mask bits read nonzero");
  AST_FAULT_A: assert property (action_a_out.fault_active |-> action_a_out.fault_mode != 3'h0)
    else $error("fault active with mode zero on A");
  AST_FAULT_B: assert property (action_b_out.fault_active |-> action_b_out.fault_mode != 3'h0)
    else $error("fault active with mode zero on B");
  AST_RETRIG_A: assert property (action_a_out.retrigger |=> !action_a_out.retrigger)
    else $error("retrigger held past one cycle");
  AST_PAIR_B: assert property (gen2_out_b0_out == gen2_out_b1_out)
    else $error("B output pins differ");
  AST_PAIR_A: assert property (gen2_out_a0_out == gen2_out_a1_out)
    else $error("A output pins differ");
endmodule // psfc_chk

// ---- verification/psfc_fault_src.sv ----
// Model of the external fault pin and comparator output.
// Assumes the bench sets its commands right after a clock edge.
`timescale 1ns/1ps
module psfc_fault_src (
  input wire logic pin_low_in,
  input wire logic cmp_high_in,
  output logic pin_out,
  output logic cmp_out
);
  // Pin idles high through a pull-up; a fault pulls it low
  assign pin_out = !pin_low_in;
  // Comparator rests low until the sensed level trips
  assign cmp_out = cmp_high_in;
endmodule // psfc_fault_src

// ---- verification/tb_top.sv ----
// Self-checking bench for the power-stage fault and capture controller.
// Assumes a 25 MHz clock and a classic Wishbone master in this module.
`timescale 1ns/1ps
module tb_top
  import psfc_pkg::*;
;
  logic clk_in = 0, sys_rst_in = 1, cyc = 0, stb = 0, we = 0, ack, pin, cmp, run2, a0, b0, a1, b1;
  logic run0 = 0, run1 = 0, arun1 = 0, eoc0 = 0, eoc2 = 0, wave_a = 1, pin_low = 0, cmp_high = 0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat;
  logic [11:0] cnt = 12'h000;
  logic [1:0] ramp = 2'h0, irq;
  psfc_block_action_t act_a, act_b;
  int error_cnt = 0, n_checks = 0;

  psfc_fault_src u_src (.pin_low_in(pin_low), .cmp_high_in(cmp_high), .pin_out(pin), .cmp_out(cmp));
  psfc_ctrl u_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
    .wb_adr_in(adr), .wb_sel_in(4'h1), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .run_gen0_in(run0), .run_gen1_in(run1), .autorun_gen1_in(arun1), .gen0_cycle_end_in(eoc0),
    .gen1_cycle_end_in(1'b0), .gen2_cycle_end_in(eoc2), .sync_error_in(2'b00), .counter_in(cnt),
    .ramp_in(ramp), .wave_a_in(wave_a), .wave_b_in(1'b0), .generator_input_pin_in(pin), .comparator_in(cmp),
    .run_gen2_out(run2), .action_a_out(act_a), .action_b_out(act_b), .irq_request_out(irq),
    .gen2_out_a0_out(a0), .gen2_out_b0_out(b0), .gen2_out_a1_out(a1), .gen2_out_b1_out(b1));

  // ********************************
  // Clock, shared tasks
  // ********************************
  initial begin
    forever #20 clk_in = ~clk_in;
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      error_cnt++;
    end
  endtask
  // One classic cycle; request held until ack is sampled
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
    @(posedge clk_in);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    @(posedge clk_in);
    while (ack !== 1'b1) @(posedge clk_in);
    q = rdat;
    cyc <= 0;
    stb <= 0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input string name, input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(name, {24'h0, exp}, q);
  endtask
  // Lets the edge updates land before outputs are looked at
  task automatic settle(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  // ********************************
  // Scenarios
  // ********************************
  task automatic t_regs();
    logic [7:0] ad[10] = '{ADDR_GEN_CONTROL, ADDR_INPUT_A_CONTROL, ADDR_INPUT_B_CONTROL, ADDR_CAPTURE_LOW,
      ADDR_CAPTURE_HIGH, ADDR_OUTPUT_MATRIX, ADDR_GEN0_IRQ_MASK, ADDR_GEN1_IRQ_MASK, ADDR_OUTPUT_CONFIG, 8'h40};
    foreach (ad[i]) rd("reset_value", ad[i], 8'h00);
    wr(8'h40, 8'hff);
    rd("unmapped", 8'h40, 8'h00);
    wr(ADDR_INPUT_B_CONTROL, 8'h79);
    rd("input_b_rw", ADDR_INPUT_B_CONTROL, 8'h79);
    wr(ADDR_GEN0_IRQ_MASK, 8'hff);
    rd("mask0", ADDR_GEN0_IRQ_MASK, 8'h39);
    wr(ADDR_GEN1_IRQ_MASK, 8'hff);
    rd("mask1", ADDR_GEN1_IRQ_MASK, 8'h39);
    wr(ADDR_INPUT_B_CONTROL, 8'h00);
    wr(ADDR_GEN1_IRQ_MASK, 8'h00);
  endtask
  task automatic t_run();
    wr(ADDR_GEN_CONTROL, 8'h05);
    settle(3);
    chk("run_bit", 32'h1, 32'(run2));
    wr(ADDR_GEN_CONTROL, 8'h04);
    settle(3);
    chk("autorun_idle", 32'h0, 32'(run2));
    run1 <= 1;
    settle(3);
    chk("autorun_gen1", 32'h1, 32'(run2));
    run1 <= 0;
    run0 <= 1;
    arun1 <= 1;
    settle(3);
    chk("autorun_chain", 32'h1, 32'(run2));
    arun1 <= 0;
    settle(3);
    chk("autorun_off", 32'h0, 32'(run2));
    run0 <= 0;
    wr(ADDR_GEN_CONTROL, 8'h06);
    run1 <= 1;
    settle(3);
    run1 <= 0;
    settle(3);
    chk("slave_no_finish", 32'h0, 32'(run2));
    wr(ADDR_GEN_CONTROL, 8'h03);
    wr(ADDR_GEN_CONTROL, 8'h02);
    settle(3);
    chk("finishing", 32'h1, 32'(run2));
    eoc2 <= 1;
    @(posedge clk_in);
    eoc2 <= 0;
    settle(3);
    chk("halted", 32'h0, 32'(run2));
    wr(ADDR_GEN_CONTROL, 8'h00);
  endtask
  task automatic t_matrix();
    logic [7:0] pm = 8'h69;
    wr(ADDR_OUTPUT_MATRIX, pm);
    // Polarity set, then clear: the matrix must win either way
    for (int p = 3; p >= 1; p -= 2) begin
      wr(ADDR_OUTPUT_CONFIG, 8'(p));
      for (int r = 0; r < 4; r++) begin
        ramp <= 2'(r);
        settle(3);
        chk("matrix_a", 32'(pm[r]), 32'(a0));
        chk("matrix_b", 32'(pm[MATRIX_B_BASE + r]), 32'(b1));
        if (p == 1) chk("matrix_no_pol", 32'(pm[r]), 32'(a1));
      end
    end
    wr(ADDR_OUTPUT_CONFIG, 8'h00);
  endtask
  task automatic t_capture();
    cnt <= 12'habc;
    wr(ADDR_INPUT_A_CONTROL, 8'h88);
    pin_low <= 1;
    settle(3);
    rd("cap_low", ADDR_CAPTURE_LOW, 8'hbc);
    rd("cap_high", ADDR_CAPTURE_HIGH, 8'h0a);
    cnt <= 12'h123;
    wr(ADDR_CAPTURE_HIGH, 8'h80);
    rd("sw_low", ADDR_CAPTURE_LOW, 8'h23);
    rd("sw_high", ADDR_CAPTURE_HIGH, 8'h81);
    wr(ADDR_INPUT_A_CONTROL, 8'h00);
    pin_low <= 0;
    wr(ADDR_INPUT_B_CONTROL, 8'he1);
    cnt <= 12'h7f5;
    pin_low <= 1;
    settle(3);
    rd("pin_not_routed", ADDR_CAPTURE_LOW, 8'h23);
    cmp_high <= 1;
    settle(3);
    rd("cmp_low", ADDR_CAPTURE_LOW, 8'hf5);
    rd("cmp_high", ADDR_CAPTURE_HIGH, 8'h07);
    pin_low <= 0;
    cmp_high <= 0;
    wr(ADDR_INPUT_B_CONTROL, 8'h00);
  endtask
  task automatic t_modes();
    psfc_block_action_t seen;
    for (int i = 0; i < 16; i++) begin
      if (i >= 10 && i != 14) continue;
      wr(ADDR_INPUT_A_CONTROL, 8'(i));
      settle(4);
      pin_low <= 1;
      seen = '0;
      repeat (4) begin
        @(posedge clk_in);
        seen = seen | act_a;
      end
      chk("fault_active", 32'(i >= 1 && i <= 7), 32'(seen.fault_active));
      if (i >= 1 && i <= 7) chk("fault_mode", 32'(i), 32'(seen.fault_mode));
      if (i == 8) chk("retrigger", 32'h1, 32'(seen.retrigger));
      chk("fixed_freq", 32'(i == 9 || i == 14), 32'(seen.fixed_frequency));
      if (i == 14) chk("deactivate", 32'h1, 32'(seen.deactivate));
      pin_low <= 0;
      settle(4);
    end
  endtask
  task automatic lat(input logic [7:0] c, output int n);
    wr(ADDR_INPUT_A_CONTROL, c);
    settle(8);
    pin_low <= 1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (act_a.event_pulse !== 1'b1 && n < 30);
    pin_low <= 0;
    settle(8);
  endtask
  task automatic t_filter();
    int n0, n1, hits;
    lat(8'h08, n0);
    lat(8'h18, n1);
    chk("filter_delay", 32'(n0 + FILTER_SAMPLES), 32'(n1));
    hits = 0;
    pin_low <= 1;
    repeat (2) @(posedge clk_in);
    pin_low <= 0;
    repeat (10) begin
      @(posedge clk_in);
      hits += int'(act_a.event_pulse === 1'b1);
    end
    chk("glitch_blocked", 32'h0, 32'(hits));
    wr(ADDR_INPUT_A_CONTROL, 8'h00);
  endtask
  task automatic t_async();
    wr(ADDR_GEN_CONTROL, 8'h08);
    wr(ADDR_INPUT_A_CONTROL, 8'h04);
    settle(3);
    chk("a_normal", 32'h0, 32'(a0));
    @(posedge clk_in);
    pin_low <= 1;
    #5;
    chk("a_async", 32'h1, 32'(a0));
    pin_low <= 0;
    wr(ADDR_INPUT_A_CONTROL, 8'h00);
    wr(ADDR_GEN_CONTROL, 8'h00);
  endtask
  task automatic t_irq();
    logic hit;
    for (int m = 1; m >= 0; m--) begin
      wr(ADDR_GEN0_IRQ_MASK, 8'(m));
      eoc0 <= 1;
      @(posedge clk_in);
      eoc0 <= 0;
      hit = 0;
      repeat (3) begin
        @(posedge clk_in);
        hit |= (irq[0] === 1'b1);
      end
      chk("end_of_cycle_irq", 32'(m), 32'(hit));
      chk("irq1_masked", 32'h0, 32'(irq[1]));
    end
  endtask

  // ********************************
  // Sequence and verdict
  // ********************************
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_in);
    sys_rst_in <= 0;
    t_regs();
    t_run();
    t_matrix();
    t_capture();
    t_modes();
    t_filter();
    t_async();
    t_irq();
    summarize();
  end
  // Whole run needs a few hundred cycles; this cuts a hang
  initial begin
    repeat (20000) @(posedge clk_in);
    error_cnt++;
    summarize();
  end
endmodule // tb_top

bind psfc_ctrl psfc_chk u_chk (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .wb_cyc_in(wb_cyc_in),
  .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_dat_out(wb_dat_out),
  .wb_ack_out(wb_ack_out), .run_gen2_out(run_gen2_out), .action_a_out(action_a_out),
  .action_b_out(action_b_out), .irq_request_out(irq_request_out), .gen2_out_a0_out(gen2_out_a0_out),
  .gen2_out_b0_out(gen2_out_b0_out), .gen2_out_a1_out(gen2_out_a1_out), .gen2_out_b1_out(gen2_out_b1_out));
